// [pkg/cfw_pkg.sv]
// types for the configuration frame writer.
// assumes nothing beyond a standard compile order.
package cfw_pkg;
    typedef logic [31:0] cfw_word_t;
    typedef enum logic [2:0] {
        ST_UNSYNC = 3'h0,
        ST_HDR = 3'h1,
        ST_CMD = 3'h2,
        ST_FAR = 3'h3,
        ST_FRAME_DATA_INPUT_REGISTER = 3'h4,
        ST_SKIP = 3'h5
    } cfw_state_t;
endpackage : cfw_pkg

// [pkg/cfw_regs.svh]
// constants for the configuration frame writer: packet fields, frame address
// layout, column sizes and abort timing; included by cfw_frame_writer only, not by cfw_buf2.
//
// Contract
// - three segments: logic fabric, two block-memory
// - block-memory segments addressed apart from fabric
// - whole frames only, no partial frame
// - column sizes 8, 48, 27, 54 frames
// - one frame length for every column
// - even columns left, odd right of centre
// - frames numbered outward from the centre
// - first frame at address, then auto-increment
// - words shift into frame register, parallel commit
// - last word stays held until pushed
// - address holds major, minor and block type
// - major field in bits 17 to 24
// - minor field in bits 9 to 16
// - user flip-flops never touched by configuration
`ifndef CFW_REGS_SVH
`define CFW_REGS_SVH

// ----------------------------------------------------------------
// packet words
// ----------------------------------------------------------------
`define CFW_SYNC_WORD 32'hAA995566
`define CFW_CMD_WRITE_CONFIG_COMMAND 32'h00000001
`define CFW_HDR_TYPE1 3'h1
`define CFW_HDR_WRITE 2'h2
`define CFW_HDR_TYPE_MSB 31
`define CFW_HDR_TYPE_LSB 29
`define CFW_HDR_OP_MSB 28
`define CFW_HDR_OP_LSB 27
`define CFW_HDR_REG_MSB 16
`define CFW_HDR_REG_LSB 13
`define CFW_HDR_CNT_MSB 10
`define CFW_REG_FAR 4'h1
`define CFW_REG_FRAME_DATA_INPUT_REGISTER 4'h2
`define CFW_REG_CMD 4'h4

// ----------------------------------------------------------------
// frame address layout
// ----------------------------------------------------------------
`define CFW_FAR_RESET 32'h00000000
`define CFW_BTYPE_MSB 26
`define CFW_BTYPE_LSB 25
`define CFW_MAJOR_MSB 24
`define CFW_MAJOR_LSB 17
`define CFW_MINOR_MSB 16
`define CFW_MINOR_LSB 9

// ----------------------------------------------------------------
// column sizes and timing
// ----------------------------------------------------------------
`define CFW_CENTER_FRAMES 8'h08
`define CFW_LOGIC_FRAMES 8'h30
`define CFW_MEMIC_FRAMES 8'h1B
`define CFW_IO_FRAMES 8'h36
`define CFW_ABORT_CYCLES 2'h3

`endif

// [pkg/cfw_stream_if.sv]
// valid/ready word stream between the writer's internal stages.
// assumes one clock shared by both ends.
`timescale 1ns/1ps
interface cfw_stream_if #(parameter int W = 32);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : cfw_stream_if

// [tb/cfw_frame_writer_tb_top.sv]
// self-checking bench for the configuration frame writer.
// assumes the storage model beside it and small frame parameters.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module cfw_frame_writer_tb_top;
    import cfw_pkg::*;
    localparam int FW = 2;
    localparam int LC = 1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n = 1'b1;
    logic wr_n = 1'b1;
    cfw_word_t din = 32'h0;
    cfw_word_t dout;
    logic busy, synced, wen, cfg_we, cfg_ready, right;
    logic [1:0] seg;
    logic [7:0] maj_o, min_o, rmaj, rmin;
    logic [FW*32-1:0] cdat;
    logic [FW*32+15:0] expq[$];
    logic [FW*32+15:0] ehead;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    int lag = 0;
    bit busy_seen = 1'b0;
    logic [7:0] tmaj[3] = '{8'h02, 8'h04, 8'h05};
    logic [7:0] tmin[3] = '{8'h2F, 8'h1A, 8'h35};

    cfw_frame_writer #(.FRAME_WORDS(FW), .LOGIC_COLS(LC)) DUT (
        .CLK(clk), .RESET(rst), .CS_N(cs_n), .WR_N(wr_n), .DATA_IN(din),
        .BUSY(busy), .DATA_OUT(dout), .SYNCED(synced), .WRITE_ENABLED(wen),
        .CFG_WE(cfg_we), .CFG_READY(cfg_ready), .CFG_SEG(seg), .CFG_MAJOR(maj_o),
        .CFG_MINOR(min_o), .CFG_RIGHT(right), .CFG_DATA(cdat));

    cfw_store_model store (.clk(clk), .rst(rst), .cfg_we(cfg_we), .lag(lag),
        .cfg_ready(cfg_ready));

    initial begin
        forever #10 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic int frames(input int m);
        if (m == 0) return 8;
        if (m <= 2 * LC) return 48;
        if (m <= 2 * LC + 2) return 27;
        return 54;
    endfunction : frames

    function automatic cfw_word_t far_w(input logic [7:0] ma, input logic [7:0] mi);
        return {7'h00, 2'h0, ma, mi, 9'h000};
    endfunction : far_w

    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic wr(input cfw_word_t w);
        logic b;
        cs_n = 1'b0;
        wr_n = 1'b0;
        din = w;
        do begin
            @(negedge clk);
            b = busy;
            if (b === 1'b1) busy_seen = 1'b1;
            @(posedge clk);
        end while (b !== 1'b0);
        #2;
    endtask : wr

    task automatic idle(input int n);
        cs_n = 1'b1;
        wr_n = 1'b1;
        din = ~din;
        repeat (n) @(posedge clk);
        #2;
    endtask : idle

    task automatic abort(input int n);
        cs_n = 1'b0;
        wr_n = 1'b1;
        repeat (n) @(posedge clk);
        #2;
        cs_n = 1'b1;
        @(posedge clk);
        #2;
    endtask : abort

    task automatic enable();
        wr(32'hAA995566);
        wr(32'h30008001);
        wr(32'h00000001);
        idle(1);
    endtask : enable

    // partial rewrite: fabric behind holds no lut memories
    task automatic fw(input logic [7:0] ma, input logic [7:0] mi, input int nf, input bit en);
        cfw_word_t w;
        logic [FW*32-1:0] fd;
        wr(32'h30002001);
        wr(far_w(ma, mi));
        wr(32'h30004000 | (nf * (FW + 1) + FW + 1));
        for (int f = 0; f <= nf; f++) begin
            fd = '0;
            for (int k = 0; k < FW; k++) begin
                w = $urandom;
                fd = {fd[FW*32-33:0], w};
                wr(w);
            end
            if (f < nf && en) begin
                expq.push_back({ma, mi, fd});
                mi = mi + 8'h01;
                if (mi == frames(ma)) begin
                    mi = 8'h00;
                    ma = ma + 8'h01;
                end
            end
            wr(32'h00000000);
        end
        idle(2);
        for (int i = 0; i < 600 && expq.size() != 0; i++) @(posedge clk);
        #2;
        `CHK(expq.size(), 0)
        if (en) `CHK(dout, far_w(ma, mi))
    endtask : fw

    // ----------------------------------------------------------------
    // commit monitor and timeout
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            results();
        end
        if (!rst && cfg_we === 1'b1 && cfg_ready === 1'b1) begin
            if (expq.size() == 0) begin
                fails++;
                $display("[ERR] t=%0t got %h exp %h", $time, {maj_o, min_o}, 16'h0);
            end else begin
                ehead = expq.pop_front();
                `CHK({maj_o, min_o, cdat}, ehead)
                `CHK(right, ehead[FW*32+8])
                `CHK(seg, 2'h0)
            end
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h9ee0));
        repeat (16) @(posedge clk);
        #2;
        rst = 1'b0;
        `CHK({synced, wen, cfg_we, busy}, 4'h0)
        `CHK(dout, 32'h00000000)
        enable();
        `CHK({synced, wen}, 2'h3)
        fw(8'h00, 8'h06, 3, 1'b1);
        for (int i = 0; i < 3; i++) begin
            lag = i * 3;
            fw(tmaj[i], tmin[i], 2, 1'b1);
        end
        lag = 12;
        fw(8'h01, 8'h00, 4, 1'b1);
        `CHK(busy_seen, 1'b1)
        lag = 0;
        wr(32'h30008001);
        wr(32'h00000007);
        idle(1);
        `CHK(wen, 1'b0)
        fw(8'h03, 8'h05, 1, 1'b0);
        `CHK(dout, far_w(8'h03, 8'h05))
        wr(32'h30006002);
        wr(32'h30002001);
        wr(far_w(8'h07, 8'h07));
        idle(1);
        `CHK(dout, far_w(8'h03, 8'h05))
        rmaj = 8'($urandom);
        rmin = 8'($urandom);
        wr(32'h30002001);
        wr(far_w(rmaj, rmin));
        idle(1);
        `CHK({maj_o, min_o, right}, {rmaj, rmin, rmaj[0]})
        `CHK(dout, far_w(rmaj, rmin))
        abort(2);
        `CHK(synced, 1'b1)
        enable();
        wr(32'h30002001);
        wr(far_w(8'h01, 8'h01));
        wr(32'h30004000 | (FW + 1) * 2);
        wr($urandom);
        wr($urandom);
        abort(3);
        `CHK({synced, wen}, 2'h0)
        `CHK(dout, far_w(8'h01, 8'h01))
        wr(32'h30008001);
        wr(32'h00000001);
        idle(4);
        `CHK(wen, 1'b0)
        enable();
        fw(8'h00, 8'h00, 1, 1'b1);
        results();
    end
endmodule : cfw_frame_writer_tb_top

// [tb/cfw_store_model.sv]
// storage-side model answering frame commits of the writer.
// assumes one clock; lag sets how many cycles a commit waits.
`timescale 1ns/1ps
module cfw_store_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_we,
    input wire logic [31:0] lag,
    output logic cfg_ready
);
    int cnt;

    // ----------------------------------------------------------------
    // commit acceptance, whole frame at once
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            cfg_ready <= 1'b0;
        end else if (!cfg_we || cfg_ready) begin
            cnt <= 0;
            cfg_ready <= #2 1'b0;
        end else if (cnt >= int'(lag)) begin
            cfg_ready <= #2 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : cfw_store_model

// [verilog/cfw_buf2.sv]
// two-entry word buffer with valid/ready on both sides.
// assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
module cfw_buf2 #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic flush,
    cfw_stream_if.dst in_s,
    cfw_stream_if.src out_s
);
    import cfw_pkg::*;

    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic wr_q, wr_d, rd_q, rd_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    if (W < 1) begin : g_chk
        $error("cfw_buf2: width must be at least one");
    end

    assign push = in_s.valid & in_s.ready;
    assign pop = out_s.valid & out_s.ready;
    assign in_s.ready = (cnt_q != 2'h2);
    assign out_s.valid = (cnt_q != 2'h0);
    assign out_s.data = mem_q[rd_q];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (flush) begin
            wr_d = 1'b0;
            rd_d = 1'b0;
            cnt_d = 2'h0;
        end else begin
            if (push) begin
                mem_d[wr_q] = in_s.data;
                wr_d = ~wr_q;
            end
            if (pop) begin
                rd_d = ~rd_q;
            end
            cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : cfw_buf2

// [verilog/cfw_frame_writer.sv]
// configuration frame write path behind the parallel configuration port.
// assumes port inputs synchronous to CLK, one word per write cycle.
`timescale 1ns/1ps
`include "cfw_regs.svh"
module cfw_frame_writer #(
    parameter int FRAME_WORDS = 18,
    parameter int LOGIC_COLS = 24
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CS_N,
    input wire logic WR_N,
    input wire cfw_pkg::cfw_word_t DATA_IN,
    output logic BUSY,
    output cfw_pkg::cfw_word_t DATA_OUT,
    output logic SYNCED,
    output logic WRITE_ENABLED,
    output logic CFG_WE,
    input wire logic CFG_READY,
    output logic [1:0] CFG_SEG,
    output logic [7:0] CFG_MAJOR,
    output logic [7:0] CFG_MINOR,
    output logic CFG_RIGHT,
    output logic [FRAME_WORDS*32-1:0] CFG_DATA
);
    import cfw_pkg::*;

    localparam int FB = FRAME_WORDS * 32;
    localparam logic [7:0] LOGIC_END = 8'(2 * LOGIC_COLS);
    localparam logic [10:0] LAST_WORD = 11'(FRAME_WORDS - 1);

    if (FRAME_WORDS < 2 || FRAME_WORDS > 2047) begin : g_chk_fw
        $error("cfw_frame_writer: FRAME_WORDS out of range");
    end
    if (LOGIC_COLS < 1 || LOGIC_COLS > 125) begin : g_chk_lc
        $error("cfw_frame_writer: LOGIC_COLS out of range");
    end

    cfw_state_t st_q, st_d;
    logic [10:0] cnt_q, cnt_d;
    logic [1:0] ab_q, ab_d;
    logic write_config_command_q, write_config_command_d;
    cfw_word_t far_q, far_d;
    cfw_word_t hold_q, hold_d;
    logic hold_v_q, hold_v_d;
    logic [11:0] left_q, left_d;
    logic [10:0] wcnt_q, wcnt_d;
    logic skip_q, skip_d;
    logic pend_q, pend_d;
    logic [FB-1:0] frame_q, frame_d;

    logic wr_en, abort_cond, abort, accept, far_wr, commit, consume, hdr_ok, frame_data_input_register_load;
    logic [3:0] hdr_reg;
    logic [10:0] hdr_cnt;
    cfw_word_t nxt_far;

    cfw_stream_if #(.W(32)) in_s ();
    cfw_stream_if #(.W(32)) out_s ();

    cfw_buf2 #(.W(32)) u_buf (
        .clk(CLK),
        .reset(RESET),
        .flush(abort),
        .in_s(in_s.dst),
        .out_s(out_s.src)
    );

    // ----------------------------------------------------------------
    // column sizes and address step
    // ----------------------------------------------------------------
    function automatic logic [7:0] col_frames(input logic [7:0] major);
        if (major == 8'h00) begin
            col_frames = `CFW_CENTER_FRAMES;
        end else if (major <= LOGIC_END) begin
            col_frames = `CFW_LOGIC_FRAMES;
        end else if (major <= LOGIC_END + 8'h02) begin
            col_frames = `CFW_MEMIC_FRAMES;
        end else begin
            col_frames = `CFW_IO_FRAMES;
        end
    endfunction : col_frames

    // minor counts outward, then next major column
    always_comb begin
        nxt_far = far_q;
        if (far_q[`CFW_MINOR_MSB:`CFW_MINOR_LSB] ==
            col_frames(far_q[`CFW_MAJOR_MSB:`CFW_MAJOR_LSB]) - 8'h01) begin
            nxt_far[`CFW_MINOR_MSB:`CFW_MINOR_LSB] = 8'h00;
            nxt_far[`CFW_MAJOR_MSB:`CFW_MAJOR_LSB] =
                far_q[`CFW_MAJOR_MSB:`CFW_MAJOR_LSB] + 8'h01;
        end else begin
            nxt_far[`CFW_MINOR_MSB:`CFW_MINOR_LSB] =
                far_q[`CFW_MINOR_MSB:`CFW_MINOR_LSB] + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // port decode
    // ----------------------------------------------------------------
    assign wr_en = !CS_N && !WR_N;
    assign abort_cond = !CS_N && WR_N;
    assign abort = abort_cond && (ab_q >= `CFW_ABORT_CYCLES - 2'h1);
    assign BUSY = (st_q == ST_FRAME_DATA_INPUT_REGISTER) && hold_v_q && !in_s.ready;
    assign accept = wr_en && !BUSY;
    assign far_wr = (st_q == ST_FAR) && accept;
    assign hdr_reg = DATA_IN[`CFW_HDR_REG_MSB:`CFW_HDR_REG_LSB];
    assign hdr_cnt = DATA_IN[`CFW_HDR_CNT_MSB:0];
    assign hdr_ok = DATA_IN[`CFW_HDR_TYPE_MSB:`CFW_HDR_TYPE_LSB] == `CFW_HDR_TYPE1
        && DATA_IN[`CFW_HDR_OP_MSB:`CFW_HDR_OP_LSB] == `CFW_HDR_WRITE
        && hdr_cnt != 11'h000;
    assign frame_data_input_register_load = (st_q == ST_HDR) && accept && hdr_ok
        && hdr_reg == `CFW_REG_FRAME_DATA_INPUT_REGISTER && write_config_command_q;
    // previous word moves on only when a new one arrives
    assign in_s.valid = (st_q == ST_FRAME_DATA_INPUT_REGISTER) && wr_en && hold_v_q;
    assign in_s.data = hold_q;

    // ----------------------------------------------------------------
    // packet state: next values
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        write_config_command_d = write_config_command_q;
        far_d = far_q;
        hold_d = hold_q;
        hold_v_d = hold_v_q;
        ab_d = abort_cond ? ((ab_q == `CFW_ABORT_CYCLES) ? ab_q : ab_q + 2'h1) : 2'h0;
        if (commit) begin
            far_d = nxt_far;
        end
        case (st_q)
            ST_UNSYNC: begin
                if (accept && DATA_IN == `CFW_SYNC_WORD) begin
                    st_d = ST_HDR;
                end
            end
            ST_HDR: begin
                if (accept && hdr_ok) begin
                    cnt_d = hdr_cnt;
                    case (hdr_reg)
                        `CFW_REG_CMD: st_d = ST_CMD;
                        `CFW_REG_FAR: st_d = ST_FAR;
                        `CFW_REG_FRAME_DATA_INPUT_REGISTER: begin
                            st_d = write_config_command_q ? ST_FRAME_DATA_INPUT_REGISTER : ST_SKIP;
                            hold_v_d = write_config_command_q ? 1'b0 : hold_v_q;
                        end
                        default: st_d = ST_SKIP;
                    endcase
                end
            end
            ST_CMD, ST_FAR, ST_FRAME_DATA_INPUT_REGISTER, ST_SKIP: begin
                if (accept) begin
                    cnt_d = cnt_q - 11'h001;
                    if (cnt_q == 11'h001) begin
                        st_d = ST_HDR;
                    end
                    if (st_q == ST_CMD) begin
                        write_config_command_d = (DATA_IN == `CFW_CMD_WRITE_CONFIG_COMMAND);
                    end
                    if (st_q == ST_FAR) begin
                        far_d = DATA_IN;
                    end
                    if (st_q == ST_FRAME_DATA_INPUT_REGISTER) begin
                        hold_d = DATA_IN;
                        hold_v_d = 1'b1;
                    end
                end
            end
            default: st_d = ST_UNSYNC;
        endcase
        if (abort) begin
            st_d = ST_UNSYNC;
            cnt_d = 11'h000;
            write_config_command_d = 1'b0;
            hold_v_d = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_q <= ST_UNSYNC;
            cnt_q <= 11'h000;
            ab_q <= 2'h0;
            write_config_command_q <= 1'b0;
            far_q <= `CFW_FAR_RESET;
            hold_q <= 32'h00000000;
            hold_v_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ab_q <= ab_d;
            write_config_command_q <= write_config_command_d;
            far_q <= far_d;
            hold_q <= hold_d;
            hold_v_q <= hold_v_d;
        end
    end

    // ----------------------------------------------------------------
    // frame assembly: next values
    // ----------------------------------------------------------------
    assign out_s.ready = !pend_q;
    assign consume = out_s.valid && out_s.ready;
    assign commit = pend_q && CFG_READY && !far_wr;

    always_comb begin
        left_d = left_q;
        wcnt_d = wcnt_q;
        skip_d = skip_q;
        pend_d = pend_q;
        frame_d = frame_q;
        if (pend_q && CFG_READY) begin
            pend_d = 1'b0;
        end
        if (consume) begin
            if (left_q != 12'h000) begin
                left_d = left_q - 12'h001;
            end
            if (skip_q) begin
                skip_d = 1'b0;
            end else begin
                frame_d = {frame_q[FB-33:0], out_s.data};
                if (wcnt_q == LAST_WORD) begin
                    wcnt_d = 11'h000;
                    // a frame with no words after it is the dummy frame
                    if (left_q > 12'h001) begin
                        pend_d = 1'b1;
                        skip_d = 1'b1;
                    end
                end else begin
                    wcnt_d = wcnt_q + 11'h001;
                end
            end
        end
        if (frame_data_input_register_load) begin
            left_d = left_d + 12'(hdr_cnt) - 12'h001;
        end
        if (abort) begin
            left_d = 12'h000;
            wcnt_d = 11'h000;
            skip_d = 1'b0;
            pend_d = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            left_q <= 12'h000;
            wcnt_q <= 11'h000;
            skip_q <= 1'b0;
            pend_q <= 1'b0;
            frame_q <= '0;
        end else begin
            left_q <= left_d;
            wcnt_q <= wcnt_d;
            skip_q <= skip_d;
            pend_q <= pend_d;
            frame_q <= frame_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs: storage side sees only whole frames
    // ----------------------------------------------------------------
    assign CFG_WE = pend_q;
    assign CFG_DATA = frame_q;
    assign CFG_SEG = far_q[`CFW_BTYPE_MSB:`CFW_BTYPE_LSB];
    assign CFG_MAJOR = far_q[`CFW_MAJOR_MSB:`CFW_MAJOR_LSB];
    assign CFG_MINOR = far_q[`CFW_MINOR_MSB:`CFW_MINOR_LSB];
    assign CFG_RIGHT = far_q[`CFW_MAJOR_LSB];
    assign DATA_OUT = far_q;
    assign SYNCED = (st_q != ST_UNSYNC);
    assign WRITE_ENABLED = write_config_command_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_far_auto_incr: assert property (
        commit |=> far_q == $past(nxt_far))
        else $error("frame address did not advance after commit");
    a_center_wrap: assert property (
        (commit && CFG_MAJOR == 8'h00 && CFG_MINOR == 8'h07)
        |=> CFG_MAJOR == 8'h01 && CFG_MINOR == 8'h00)
        else $error("centre column did not end after eight frames");
    a_hold_stuck: assert property (
        (st_q == ST_FRAME_DATA_INPUT_REGISTER && accept && !abort)
        |=> hold_v_q && hold_q == $past(DATA_IN) && st_q != ST_UNSYNC)
        else $error("last written word not held in input register");
    a_commit_stable: assert property (
        (CFG_WE && !CFG_READY && !abort && !far_wr)
        |=> CFG_WE && $stable(CFG_DATA) && $stable(CFG_MINOR))
        else $error("pending frame changed before storage took it");
    a_whole_frame: assert property (
        $rose(CFG_WE) |-> wcnt_q == 11'h000 && skip_q)
        else $error("commit raised without a full frame");
    a_major_field: assert property (
        (far_wr && !abort) |=> CFG_MAJOR == $past(DATA_IN[24:17]))
        else $error("major field not taken from bits 24..17");
    a_minor_field: assert property (
        (far_wr && !abort) |=> CFG_MINOR == $past(DATA_IN[16:9]))
        else $error("minor field not taken from bits 16..9");
    a_abort_resync: assert property (
        abort_cond [*3] |=> !SYNCED && !WRITE_ENABLED)
        else $error("abort sequence did not resynchronise port");
    a_write_config_command_gate: assert property (
        (st_q == ST_HDR && accept && hdr_ok && hdr_reg == `CFW_REG_FRAME_DATA_INPUT_REGISTER
         && !write_config_command_q && !abort) |=> st_q == ST_SKIP)
        else $error("frame data accepted without write enable");

    c_sync: cover property (st_q == ST_UNSYNC ##1 st_q == ST_HDR);
    c_commit: cover property (CFG_WE && CFG_READY);
    c_stall: cover property (BUSY [*2]);
    c_abort: cover property (abort && write_config_command_q);
endmodule : cfw_frame_writer
